// *** hdl/tcs_pkg.sv ***
// Purpose: Shared constants for the tape controller command and status flag logic
// Assumes: 18-bit processor word, bit 0 is the least significant bit of each field
// Notes: Command codes are the six-digit octal instruction codes
package tcs_pkg;
    // Device command instruction codes (octal)
    localparam logic [17:0] TCS_CMD_CLEAR = 18'o707541;
    localparam logic [17:0] TCS_CMD_READ_CW = 18'o707552;
    localparam logic [17:0] TCS_CMD_XOR = 18'o707544;
    localparam logic [17:0] TCS_CMD_LOAD = 18'o707545;
    localparam logic [17:0] TCS_CMD_SKIP_ERR = 18'o707561;
    localparam logic [17:0] TCS_CMD_READ_SW = 18'o707572;
    localparam logic [17:0] TCS_CMD_SKIP_DONE = 18'o707601;
    // Command word width and field positions
    localparam int TCS_CW_W = 10;
    localparam int TCS_UNIT_LSB = 0;
    localparam int TCS_DIR_BIT = 3;
    localparam int TCS_GO_BIT = 4;
    localparam int TCS_MODE_BIT = 5;
    localparam int TCS_FN_LSB = 6;
    localparam int TCS_IE_BIT = 9;
    // Flag control bits in the processor word
    localparam int TCS_KEEP_ERR_BIT = 10;
    localparam int TCS_KEEP_DONE_BIT = 11;
    // Status word positions
    localparam int TCS_ST_ERR = 0;
    localparam int TCS_ST_MARK = 1;
    localparam int TCS_ST_EOT = 2;
    localparam int TCS_ST_SEL = 3;
    localparam int TCS_ST_PAR = 4;
    localparam int TCS_ST_TIM = 5;
    localparam int TCS_ST_DONE = 11;
    localparam int TCS_SEL_BITS_HI = 4;
    // Memory locations used by the data channel and the interrupt vector
    localparam logic [5:0] TCS_LOC_COUNT = 6'o30;
    localparam logic [5:0] TCS_LOC_POINTER = 6'o31;
    localparam logic [5:0] TCS_LOC_VECTOR = 6'o44;
    localparam logic [1:0] TCS_INT_LEVEL = 2'h1;
    // Select delay
    localparam int TCS_CLK_HZ = 25000000;
    localparam int TCS_SEL_DELAY_MS = 140;
    localparam int TCS_SEL_DELAY_CYC = TCS_SEL_DELAY_MS * (TCS_CLK_HZ / 1000);
    localparam logic [17:0] TCS_ZERO_WORD = 18'h00000;
    // Function codes
    typedef enum logic [2:0] {
        TCS_FN_MOVE = 3'h0,
        TCS_FN_SEARCH = 3'h1,
        TCS_FN_READ_DATA = 3'h2,
        TCS_FN_READ_ALL = 3'h3,
        TCS_FN_WRITE_DATA = 3'h4,
        TCS_FN_WRITE_ALL = 3'h5,
        TCS_FN_WRITE_TIMING = 3'h6,
        TCS_FN_UNUSED = 3'h7
    } tcs_fn_e;
endpackage

// *** hdl/tcs_delay.sv ***
// Purpose: Select delay timer started by a pulse, busy while counting
// Assumes: Count is at least one cycle
// Notes: A new start restarts the count
`timescale 1ns/10ps
module tcs_delay #(
    parameter int COUNT = 3500000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic start,
    output logic busy
);
    localparam int CW = $clog2(COUNT + 1);
    logic [CW-1:0] cnt_r; // Remaining cycles
    logic busy_r; // Registered so the top output comes from a flip-flop

    // Down counter, restartable; busy drops on the edge the count hits zero
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else if (start) begin
            cnt_r <= CW'(COUNT);
            busy_r <= 1'b1;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - CW'(1);
            busy_r <= (cnt_r != CW'(1));
        end
    end

    assign busy = busy_r;
endmodule

// *** hdl/tcs_zero_fill.sv ***
// Purpose: Track count overflow within a write block and force zero data after it
// Assumes: Block boundaries and count overflow strobes come from the transfer sequencer
// Notes: Held until the next block starts
`timescale 1ns/10ps
module tcs_zero_fill #(
    parameter int W = 18
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Block events
    input wire logic block_start,
    input wire logic count_overflow,
    // Data path
    input wire logic [W-1:0] mem_word,
    output logic [W-1:0] tape_word,
    output logic fetch_allowed,
    output logic overflowed
);
    logic ovf_r; // Overflow seen this block

    // Overflow tracking, set wins over block restart
    always_ff @(posedge clock) begin
        if (rst) begin
            ovf_r <= 1'b0;
        end else if (count_overflow) begin
            ovf_r <= 1'b1;
        end else if (block_start) begin
            ovf_r <= 1'b0;
        end
    end

    assign overflowed = ovf_r;
    assign fetch_allowed = !ovf_r;
    assign tape_word = ovf_r ? '0 : mem_word;
endmodule

// *** hdl/tcs_top.sv ***
// Purpose: Command word, error flags and done flag of a block tape controller
// Assumes: Command strobe is one cycle, bus inputs synchronous to clock
// Notes: Outputs other than the fixed vector, level and locations are registered and lag their cause by one cycle
`timescale 1ns/10ps
module tcs_top
    import tcs_pkg::*;
#(
    parameter int SEL_DELAY = TCS_SEL_DELAY_CYC,
    parameter int WORD_W = 18
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Device command bus
    input wire logic cmd_valid,
    input wire logic [17:0] cmd_code,
    input wire logic [WORD_W-1:0] main_reg_in,
    output logic [WORD_W-1:0] main_reg_out,
    output logic main_reg_load,
    output logic skip_pulse,
    // Interrupt
    output logic int_req,
    output logic [5:0] int_vector,
    output logic [1:0] int_level,
    // Data channel locations
    output logic [5:0] count_loc,
    output logic [5:0] pointer_loc,
    output logic dch_allow,
    // Transport and sequencer events
    input wire logic block_start,
    input wire logic block_end,
    input wire logic count_overflow,
    input wire logic word_done,
    input wire logic mark_bad,
    input wire logic end_zone,
    input wire logic check_fail,
    input wire logic data_miss,
    input wire logic over_data_area,
    input wire logic unit_count_bad,
    input wire logic write_locked,
    input wire logic unit_offline,
    input wire logic format_switch_position,
    // Write data path
    input wire logic [WORD_W-1:0] mem_word,
    output logic [WORD_W-1:0] tape_word,
    output logic mem_fetch_en,
    // Transport control
    output logic [TCS_CW_W-1:0] command_word,
    output logic writers_en,
    output logic select_busy
);
    logic [TCS_CW_W-1:0] cw_r; // Command word
    logic err_mark_r, err_eot_r, err_sel_r, err_par_r, err_tim_r; // Error bits
    logic done_r; // Done flag
    logic tim_stop, tim_ovf; // Timing errors that stop, and the overflow one that does not
    logic wr_dis_r; // Writers disabled after overflow
    logic dch_r; // Word-count flip-flop
    logic [WORD_W-1:0] reg_out_r;
    logic reg_load_r, skip_r, int_r, wen_r, fetch_r;
    logic [WORD_W-1:0] tape_r;
    logic [2:0] fn;
    logic cont_mode, go;
    logic is_clear, is_xor, is_load, is_read_cw, is_read_sw, is_skip_e, is_skip_d;
    logic sum_err, new_err_stop, sel_cond, par_now, tim_cond, mark_cond, eot_cond;
    logic [WORD_W-1:0] fill_word;
    logic ovf_block, fetch_ok, delay_start, delay_busy;
    logic prev_dir_r; // Direction at last block start
    logic is_write;

    // Command decode helper
    function automatic logic cmd_is(input logic [17:0] c, input logic [17:0] ref_c);
        return cmd_valid && (c == ref_c);
    endfunction

    // Write-function test used by select and writer logic
    function automatic logic fn_writes(input logic [2:0] f);
        return (f == TCS_FN_WRITE_DATA) || (f == TCS_FN_WRITE_ALL) ||
            (f == TCS_FN_WRITE_TIMING);
    endfunction

    assign fn = cw_r[TCS_FN_LSB +: 3];
    assign cont_mode = cw_r[TCS_MODE_BIT];
    assign go = cw_r[TCS_GO_BIT];
    assign is_write = fn_writes(fn);
    assign is_clear = cmd_is(cmd_code, TCS_CMD_CLEAR);
    assign is_xor = cmd_is(cmd_code, TCS_CMD_XOR);
    assign is_load = cmd_is(cmd_code, TCS_CMD_LOAD);
    assign is_read_cw = cmd_is(cmd_code, TCS_CMD_READ_CW);
    assign is_read_sw = cmd_is(cmd_code, TCS_CMD_READ_SW);
    assign is_skip_e = cmd_is(cmd_code, TCS_CMD_SKIP_ERR);
    assign is_skip_d = cmd_is(cmd_code, TCS_CMD_SKIP_DONE);

    assign sel_cond = go && (unit_count_bad || (is_write && write_locked) || unit_offline ||
        ((fn == TCS_FN_WRITE_TIMING) != format_switch_position) || (fn == TCS_FN_UNUSED));
    // mark error not in move or timing write
    assign mark_cond = mark_bad && go && (fn != TCS_FN_MOVE) && (fn != TCS_FN_WRITE_TIMING);
    // end zone with go and unchanged direction
    assign eot_cond = end_zone && go && (cw_r[TCS_DIR_BIT] == prev_dir_r);
    // parity only in read data at block end
    assign par_now = block_end && check_fail && (fn == TCS_FN_READ_DATA);
    // data miss, done not cleared, or data switch over data
    assign tim_stop = data_miss || (block_start && done_r && go) ||
        ((is_xor || is_load) && over_data_area &&
        ((main_reg_in[TCS_FN_LSB +: 3] == TCS_FN_READ_DATA) ||
        (main_reg_in[TCS_FN_LSB +: 3] == TCS_FN_WRITE_DATA)));
    // overflow timing error keeps the tape moving
    assign tim_ovf = block_end && ovf_block && fn == TCS_FN_WRITE_DATA && !cont_mode;
    assign tim_cond = tim_stop || tim_ovf;
    assign new_err_stop = sel_cond || mark_cond || eot_cond || tim_stop;
    // summary is OR of all error bits
    assign sum_err = err_mark_r | err_eot_r | err_sel_r | err_par_r | err_tim_r;
    assign delay_start = is_load || (is_xor && |main_reg_in[TCS_SEL_BITS_HI:0]);

    tcs_delay #(.COUNT(SEL_DELAY)) u_delay (
        .clock(clock),
        .rst(rst),
        .start(delay_start),
        .busy(delay_busy)
    );

    tcs_zero_fill #(.W(WORD_W)) u_fill (
        .clock(clock),
        .rst(rst),
        .block_start(block_start),
        .count_overflow(count_overflow),
        .mem_word(mem_word),
        .tape_word(fill_word),
        .fetch_allowed(fetch_ok),
        .overflowed(ovf_block)
    );

    // Direction tracking for end zone test
    always_ff @(posedge clock) begin
        if (rst) begin
            prev_dir_r <= 1'b0;
        end else if (block_start) begin
            prev_dir_r <= cw_r[TCS_DIR_BIT];
        end
    end

    // Command word; errors that stop the transport drop go
    always_ff @(posedge clock) begin
        if (rst) begin
            cw_r <= '0;
        end else if (is_clear) begin
            cw_r <= '0;
        end else if (is_load) begin
            cw_r <= main_reg_in[TCS_CW_W-1:0];
        end else if (is_xor) begin
            cw_r <= cw_r ^ main_reg_in[TCS_CW_W-1:0];
        end else if (new_err_stop) begin
            cw_r[TCS_GO_BIT] <= 1'b0;
        end
    end

    // Error bits; a new error wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            err_mark_r <= 1'b0;
            err_eot_r <= 1'b0;
            err_sel_r <= 1'b0;
            err_par_r <= 1'b0;
            err_tim_r <= 1'b0;
        end else begin
            if ((is_xor || is_load) && !main_reg_in[TCS_KEEP_ERR_BIT]) begin
                err_mark_r <= 1'b0;
                err_eot_r <= 1'b0;
                err_sel_r <= 1'b0;
                err_par_r <= 1'b0;
                err_tim_r <= 1'b0;
            end
            if (mark_cond) err_mark_r <= 1'b1;
            if (eot_cond) err_eot_r <= 1'b1;
            if (sel_cond) err_sel_r <= 1'b1;
            if (tim_cond) err_tim_r <= 1'b1;
            // normal parity goes up at block end with done
            // continuous parity goes up at block end too
            if (par_now) err_par_r <= 1'b1;
        end
    end

    // Done flag: block end, not in move (continuous only after overflow), or each normal-mode word of read/write all and write timing; not on stopping errors
    always_ff @(posedge clock) begin
        if (rst) begin
            done_r <= 1'b0;
        end else if (block_end && !new_err_stop &&
            (!cont_mode || ovf_block || count_overflow) && fn != TCS_FN_MOVE) begin
            // continuous write data done at overflow block end
            done_r <= 1'b1;
        end else if (word_done && !cont_mode &&
            (fn == TCS_FN_READ_ALL || fn == TCS_FN_WRITE_ALL ||
            fn == TCS_FN_WRITE_TIMING) && !new_err_stop) begin
            done_r <= 1'b1;
        end else if ((is_xor || is_load) && !main_reg_in[TCS_KEEP_DONE_BIT]) begin
            done_r <= 1'b0;
        end
    end

    // Writers and data fetch after overflow
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_dis_r <= 1'b0;
            wen_r <= 1'b0;
            fetch_r <= 1'b0;
            tape_r <= TCS_ZERO_WORD;
            dch_r <= 1'b0;
        end else begin
            // write all stops after overflow word
            // writers disabled once overflow block ends
            // Set wins over a new command in the same cycle
            if ((count_overflow && fn == TCS_FN_WRITE_ALL) ||
                (block_end && ovf_block && fn == TCS_FN_WRITE_DATA)) begin
                wr_dis_r <= 1'b1;
            end else if (is_xor || is_load) begin
                wr_dis_r <= 1'b0;
            end
            wen_r <= go && is_write && !wr_dis_r && !delay_busy;
            fetch_r <= go && is_write && fetch_ok && !count_overflow;
            tape_r <= fill_word;
            if (is_xor) begin
                dch_r <= 1'b1;
            end else if (count_overflow) begin
                dch_r <= 1'b0;
            end
        end
    end

    // Register reads and skips
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_out_r <= '0;
            reg_load_r <= 1'b0;
            skip_r <= 1'b0;
        end else begin
            reg_load_r <= is_read_cw || is_read_sw;
            reg_out_r <= '0;
            if (is_read_cw) begin
                // register cleared, command word ORed in
                reg_out_r <= WORD_W'(cw_r);
            end else if (is_read_sw) begin
                // register cleared, bits 0-5 and done at 11
                reg_out_r[TCS_ST_ERR] <= sum_err;
                reg_out_r[TCS_ST_MARK] <= err_mark_r;
                reg_out_r[TCS_ST_EOT] <= err_eot_r;
                reg_out_r[TCS_ST_SEL] <= err_sel_r;
                reg_out_r[TCS_ST_PAR] <= err_par_r;
                reg_out_r[TCS_ST_TIM] <= err_tim_r;
                reg_out_r[TCS_ST_DONE] <= done_r;
            end
            skip_r <= (is_skip_e && sum_err) || (is_skip_d && done_r);
        end
    end

    // Interrupt request
    always_ff @(posedge clock) begin
        if (rst) begin
            int_r <= 1'b0;
        end else begin
            int_r <= cw_r[TCS_IE_BIT] && (sum_err || done_r);
        end
    end

    assign count_loc = TCS_LOC_COUNT;
    assign pointer_loc = TCS_LOC_POINTER;
    assign int_vector = TCS_LOC_VECTOR;
    assign int_level = TCS_INT_LEVEL;
    assign main_reg_out = reg_out_r;
    assign main_reg_load = reg_load_r;
    assign skip_pulse = skip_r;
    assign int_req = int_r;
    assign dch_allow = dch_r;
    assign tape_word = tape_r;
    assign mem_fetch_en = fetch_r;
    assign command_word = cw_r;
    assign writers_en = wen_r;
    assign select_busy = delay_busy;

    // Assertions
    property p_int_gate;
        @(posedge clock) disable iff (rst) !cw_r[TCS_IE_BIT] |=> !int_req;
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("int without enable");
    property p_int_req;
        @(posedge clock) disable iff (rst) (cw_r[TCS_IE_BIT] && done_r) |=> int_req;
    endproperty
    a_int_req: assert property (p_int_req) else $error("int missing");
    property p_clear;
        @(posedge clock) disable iff (rst) is_clear |=> (cw_r == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    property p_stop;
        @(posedge clock) disable iff (rst)
            (sel_cond && !is_clear && !is_load && !is_xor) |=> !go && err_sel_r;
    endproperty
    a_stop: assert property (p_stop) else $error("select error did not stop");
    property p_skip;
        @(posedge clock) disable iff (rst) (is_skip_d && done_r) |=> skip_pulse;
    endproperty
    a_skip: assert property (p_skip) else $error("skip missing");
    property p_par_fn;
        @(posedge clock) disable iff (rst)
            ($rose(err_par_r)) |-> $past(fn) == TCS_FN_READ_DATA;
    endproperty
    a_par_fn: assert property (p_par_fn) else $error("parity outside read");
    property p_load;
        @(posedge clock) disable iff (rst)
            is_load |=> cw_r == $past(main_reg_in[TCS_CW_W-1:0]) ##1 select_busy;
    endproperty
    a_load: assert property (p_load) else $error("load failed");
    property p_mark;
        @(posedge clock) disable iff (rst) $rose(err_mark_r) |-> $past(fn) != TCS_FN_MOVE;
    endproperty
    a_mark: assert property (p_mark) else $error("mark error in move");
    c_load: cover property (@(posedge clock) is_load);
    c_int: cover property (@(posedge clock) int_req);
    c_ovf: cover property (@(posedge clock) count_overflow ##[1:20] block_end);
endmodule

// *** bench/tcs_chan_model.sv ***
// Purpose: Model of the sequencer and data channel feeding one tape block
// Assumes: Events are one-cycle pulses changed off the falling edge
// Notes: Outside a word the memory bus shows a changing pattern, not stale data
`timescale 1ns/10ps
module tcs_chan_model #(
    parameter int WORDS = 4,
    parameter int OVF = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Block request from the bench
    input wire logic run,
    output logic busy,
    // Sequencer events
    output logic block_start,
    output logic block_end,
    output logic count_overflow,
    output logic word_done,
    // Memory word from the channel
    output logic [17:0] mem_word
);
    int step = 0; // Position within the block, 0 is idle
    logic run_q = 1'b0; // Run taken at the rising edge, free of races with the bench
    always @(posedge clock) run_q <= run;
    initial begin
        busy = 1'b0;
        block_start = 1'b0;
        block_end = 1'b0;
        count_overflow = 1'b0;
        word_done = 1'b0;
        mem_word = 18'h2aaaa;
    end
    // One block: start, WORDS words, end, then a quiet gap
    always @(negedge clock) begin
        block_start = 1'b0;
        block_end = 1'b0;
        count_overflow = 1'b0;
        word_done = 1'b0;
        // Released bus toggles so a stale word is never mistaken for data
        mem_word = ~mem_word;
        if (rst) begin
            step = 0;
        end else if (step == 0 && run_q) begin
            step = 1;
        end else if (step > 0) begin
            step = step + 1;
        end
        if (step == 1) begin
            block_start = 1'b1;
        end
        if (step >= 2 && step <= WORDS + 1) begin
            word_done = 1'b1;
            mem_word = 18'h01000 + 18'(step);
            count_overflow = (step == OVF + 1);
        end
        if (step == WORDS + 2) begin
            block_end = 1'b1;
        end
        // host waits after overflow before a new function
        if (step == WORDS + 8) begin
            step = 0;
        end
        busy = (step != 0);
    end
endmodule

// *** bench/testbench.sv ***
// Purpose: Self-checking bench for the tape command and status flag logic
// Assumes: Select delay shortened to 8 cycles, bench drives on falling edge
// Notes: Pulse outputs are searched for over three cycles after a command
`timescale 1ns/10ps
module testbench;
    import tcs_pkg::*;
    typedef struct packed {
        logic [17:0] code;
        logic [17:0] din;
        logic [9:0] cw;
        logic [17:0] out;
        logic load;
        logic skip;
        logic busy;
    } tcs_row_s;
    // Clock, reset and command bus
    logic clock = 0, rst = 1, cmd_valid = 0, run = 0, pbusy;
    logic [17:0] cmd_code = 0, main_reg_in = 0, main_reg_out, mem_word, tape_word;
    // Event inputs, the levels mostly stay idle
    logic mark_bad = 0, check_fail = 0, data_miss = 0, write_locked = 0;
    logic end_zone = 0, over_data_area = 0, unit_count_bad = 0, unit_offline = 0;
    logic format_switch_position = 0;
    logic block_start, block_end, count_overflow, word_done;
    // Design outputs
    logic main_reg_load, skip_pulse, int_req, dch_allow, mem_fetch_en, writers_en;
    logic select_busy;
    logic [5:0] int_vector, count_loc, pointer_loc;
    logic [1:0] int_level;
    logic [9:0] command_word;
    // Scoreboard and captured answers
    int bad_count = 0, samples_checked = 0;
    logic got_load, got_skip;
    logic [17:0] got_out;
    tcs_row_s rows [9];

    tcs_top #(.SEL_DELAY(8)) uut (
        .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .main_reg_in(main_reg_in), .main_reg_out(main_reg_out),
        .main_reg_load(main_reg_load), .skip_pulse(skip_pulse), .int_req(int_req),
        .int_vector(int_vector), .int_level(int_level), .count_loc(count_loc),
        .pointer_loc(pointer_loc), .dch_allow(dch_allow), .block_start(block_start),
        .block_end(block_end), .count_overflow(count_overflow), .word_done(word_done),
        .mark_bad(mark_bad), .end_zone(end_zone), .check_fail(check_fail),
        .data_miss(data_miss), .over_data_area(over_data_area),
        .unit_count_bad(unit_count_bad), .write_locked(write_locked),
        .unit_offline(unit_offline), .format_switch_position(format_switch_position),
        .mem_word(mem_word), .tape_word(tape_word), .mem_fetch_en(mem_fetch_en),
        .command_word(command_word), .writers_en(writers_en), .select_busy(select_busy));

    tcs_chan_model #(.WORDS(4), .OVF(2)) chan (
        .clock(clock), .rst(rst), .run(run), .busy(pbusy), .block_start(block_start),
        .block_end(block_end), .count_overflow(count_overflow), .word_done(word_done),
        .mem_word(mem_word));

    // 25 MHz clock
    initial begin
        forever #20 clock = ~clock;
    end

    // Compare one value and count it
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Report counts and verdict, then stop
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One command, then watch three cycles for its pulses
    task automatic issue(input logic [17:0] code, input logic [17:0] din);
        @(negedge clock);
        cmd_valid = 1;
        cmd_code = code;
        main_reg_in = din;
        @(negedge clock);
        cmd_valid = 0;
        got_load = 0;
        got_skip = 0;
        got_out = 0;
        repeat (3) begin
            if (main_reg_load === 1'b1) begin
                got_load = 1;
                got_out = main_reg_out;
            end
            if (skip_pulse === 1'b1) begin
                got_skip = 1;
            end
            @(negedge clock);
        end
    endtask

    // One-cycle event pulse: 1 mark, 2 miss, 4 check fail, 8 end zone
    task automatic pulse_ev(input int ev);
        @(negedge clock);
        mark_bad = (ev == 1);
        data_miss = (ev == 2);
        check_fail = (ev == 4);
        end_zone = (ev == 8);
        @(negedge clock);
        mark_bad = 0;
        data_miss = 0;
        check_fail = 0;
        end_zone = 0;
    endtask

    // Run one block through the channel model, bounded wait
    task automatic run_block(input int ev);
        int n;
        @(negedge clock);
        run = 1;
        @(negedge clock);
        run = 0;
        // Event lands on the block end cycle
        repeat (4) @(negedge clock);
        pulse_ev(ev);
        for (n = 0; n < 40 && pbusy === 1'b1; n++) @(negedge clock);
        if (n == 40) begin
            bad_count++;
            complete_run();
        end
    endtask

    // Error source, status bit expected, go must drop
    task automatic err_case(input logic [17:0] cw, input int ev, input int bitn);
        write_locked = (ev == 3);
        issue(TCS_CMD_LOAD, cw);
        pulse_ev(ev);
        issue(TCS_CMD_READ_SW, 18'h0);
        check(got_out, 18'h1 | (18'h1 << bitn));
        check(command_word[TCS_GO_BIT], 0);
        check(int_req, 0);
        issue(TCS_CMD_SKIP_ERR, 18'h0);
        check(got_skip, 1);
        write_locked = 0;
    endtask

    initial begin
        rows[0] = '{TCS_CMD_LOAD, 18'hca5, 10'h0a5, 18'h0, 0, 0, 1};
        rows[1] = '{TCS_CMD_READ_CW, 18'h3000, 10'h0a5, 18'h000a5, 1, 0, 0};
        rows[2] = '{TCS_CMD_XOR, 18'hc20, 10'h085, 18'h0, 0, 0, 0};
        rows[3] = '{TCS_CMD_XOR, 18'hc01, 10'h084, 18'h0, 0, 0, 1};
        rows[4] = '{TCS_CMD_CLEAR, 18'h0, 10'h000, 18'h0, 0, 0, 0};
        rows[5] = '{TCS_CMD_SKIP_ERR, 18'h0, 10'h000, 18'h0, 0, 0, 0};
        rows[6] = '{TCS_CMD_SKIP_DONE, 18'h0, 10'h000, 18'h0, 0, 0, 0};
        rows[7] = '{18'o707500, 18'h3ff, 10'h000, 18'h0, 0, 0, 0};
        rows[8] = '{TCS_CMD_READ_SW, 18'h20040, 10'h000, 18'h00000, 1, 0, 0};
        repeat (20) @(negedge clock);
        rst = 0;
        // Reset state and fixed locations
        check(command_word, 0);
        check({int_vector, count_loc, pointer_loc}, {6'o44, 6'o30, 6'o31});
        check(int_level, 1);
        // Ordinary command rows
        foreach (rows[i]) begin
            issue(rows[i].code, rows[i].din);
            check(command_word, rows[i].cw);
            check(select_busy, rows[i].busy);
            check(got_load, rows[i].load);
            check(got_out, rows[i].out);
            check(got_skip, rows[i].skip);
            repeat (10) @(negedge clock);
        end
        // Stopping errors with interrupt disabled
        err_case(18'h090, 1, TCS_ST_MARK);
        err_case(18'h090, 2, TCS_ST_TIM);
        err_case(18'h110, 3, TCS_ST_SEL);
        err_case(18'h1d0, 0, TCS_ST_SEL);
        err_case(18'h090, 8, TCS_ST_EOT);
        // Enabled interrupt, then flag clear through bit 10
        issue(TCS_CMD_LOAD, 18'h290);
        pulse_ev(1);
        repeat (2) @(negedge clock);
        check(int_req, 1);
        issue(TCS_CMD_LOAD, 18'ha00);
        check(int_req, 0);
        // Parity error ignored outside read data
        issue(TCS_CMD_LOAD, 18'h050);
        run_block(4);
        issue(TCS_CMD_READ_SW, 18'h0);
        check(got_out & 18'h11, 0);
        // Normal-mode parity: go stays, error with done
        issue(TCS_CMD_LOAD, 18'h090);
        run_block(4);
        issue(TCS_CMD_READ_SW, 18'h0);
        check(got_out, 18'h811);
        check(command_word[TCS_GO_BIT], 1);
        issue(TCS_CMD_SKIP_DONE, 18'h0);
        check(got_skip, 1);
        // Continuous-mode parity: error with done at the overflow block end
        issue(TCS_CMD_LOAD, 18'h0b0);
        run_block(4);
        issue(TCS_CMD_READ_SW, 18'h0);
        check(got_out, 18'h811);
        // Write all: writers off after the overflow word
        issue(TCS_CMD_LOAD, 18'h150);
        run_block(0);
        check(writers_en, 0);
        // Write data with overflow mid-block
        issue(TCS_CMD_LOAD, 18'h110);
        issue(TCS_CMD_XOR, 18'hc00);
        check(dch_allow, 1);
        @(negedge clock);
        check(writers_en, 1);
        run_block(0);
        check(dch_allow, 0);
        check(command_word[TCS_GO_BIT], 1);
        check(tape_word, 0);
        check(mem_fetch_en, 0);
        check(writers_en, 0);
        issue(TCS_CMD_READ_SW, 18'h0);
        check(got_out[TCS_ST_TIM], 1);
        // Reset in mid-run
        @(negedge clock);
        rst = 1;
        @(negedge clock);
        rst = 0;
        check(command_word, 0);
        issue(TCS_CMD_READ_SW, 18'h0);
        check(got_out, 0);
        complete_run();
    end
endmodule
